/* File: hw/swr_params.svh */
// Register offsets, field positions, reset values and timing counts of the sleep and free-running timers
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SWR_OFF_SLEEP_COUNT 12'h020
`define SWR_OFF_SLEEP_CMP 12'h024
`define SWR_OFF_FREE_COUNT 12'h028
`define SWR_OFF_CTRL 12'h040
`define SWR_OFF_STATUS 12'h044
`define SWR_OFF_MASK 12'h048

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SWR_CTRL_SLOW_XTAL 0
`define SWR_CTRL_WAKE_EN 1
`define SWR_CTRL_FREE_EN 2
`define SWR_CTRL_FREE_XTAL 3
`define SWR_CTRL_W 4

// ----------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------
`define SWR_ST_SYNC 0
`define SWR_ST_HIB_WAKE 1
`define SWR_ST_TIMER 2
`define SWR_ST_W 3

// ----------------------------------------------------------------
// Tick sources and reset values
// ----------------------------------------------------------------
`define SWR_SRC_RING 0
`define SWR_SRC_XTAL 1
`define SWR_SRC_REF 2
`define SWR_SRC_N 3
`define SWR_REF_DIV 128
`define SWR_RST_WORD 32'h0000_0000
`define SWR_RST_CTRL 4'h0
`define SWR_RST_ST 3'h0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SWR_WAKE_TICKS 4

`endif

/* File: hw/swr_pkg.sv */
// Types shared by the sleep and free-running timer block
`default_nettype none

package swr_pkg;

	// Sleep sequence states, Gray coded along the normal path
	typedef enum logic [1:0] {
		st_awake = 2'b00,
		st_entry = 2'b01,
		st_asleep = 2'b11,
		st_waking = 2'b10
	} swr_state_e;

	typedef logic [31:0] swr_word_t;

endpackage

`default_nettype wire

/* File: hw/swr_tick_sync.sv */
// Synchronisers and rising-edge tick detectors for the slow clock inputs
`timescale 1ns/1ps
`default_nettype none

module swr_tick_sync #(
	parameter int N = 3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Slow clock levels and their edge pulses
	input wire logic [N-1:0] slow_in,
	output logic [N-1:0] tick
);

	// Refuse an empty source list at elaboration
	if (N < 1) begin : g_bad_n
		$error("swr_tick_sync: N must be at least 1");
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			logic meta_r, sync_r, prev_r;
			logic meta_nxt, sync_nxt, prev_nxt;

			always_comb begin
				meta_nxt = slow_in[g];
				sync_nxt = meta_r;
				prev_nxt = sync_r;
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
					prev_r <= 1'b0;
				end else begin
					meta_r <= meta_nxt;
					sync_r <= sync_nxt;
					prev_r <= prev_nxt;
				end
			end

			// One pclk pulse per rising edge of the slow clock
			assign tick[g] = sync_r & ~prev_r;
		end
	endgenerate

endmodule

`default_nettype wire

/* File: hw/swr_sleep_timers.sv */
// Wake-up sleep timer and free-running counter with APB register access
//
// Functional notes
// - Sleep entry clears the sleep counter, which then counts sleep-clock ticks.
// - Sleep counter is 32 bits, read-only, zero after reset.
// - Compare contents are kept unchanged through sleep; counter contents are kept while it counts.
// - Sleep clock is ring, crystal (select bit) or reference divided by 128.
// - Hibernate uses ring or crystal; doze uses reference divided by 128.
// - 32-bit read-write compare register, zero at reset, sets sleep duration.
// - Wake-up takes further sleep-clock ticks after the compare point.
// - Free-running 32-bit up-counter from zero, wrapping after all ones.
// - Free-running counter advances only while ring or crystal clock is enabled.
// - Free-running counter is read-only, software cannot clear or load it.
// - No compensation when the free-running clock source switches.
// - Sync flag sets at sleep start and at wake point; clearing it after sleep start freezes clocks.
// - Hibernate wake flag sets only with timer wake enable; write one clears.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "swr_params.svh"

module swr_sleep_timers
	import swr_pkg::*;
#(
	parameter int WAKE_TICKS = `SWR_WAKE_TICKS
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Slow clocks from pins
	input wire logic ring_2k_clk,
	input wire logic xtal_32k_clk,
	input wire logic ref_div_clk,
	// Power sequencing, one-cycle requests
	input wire logic hib_req,
	input wire logic doze_req,
	// Status toward the system
	output logic clk_freeze,
	output logic irq
);

	// Wake tick counter is four bits wide
	if (WAKE_TICKS < 1 || WAKE_TICKS > 15) begin : g_bad_wake
		$error("swr_sleep_timers: WAKE_TICKS must be 1 to 15");
	end

	// ----------------------------------------------------------------
	// Slow clock ticks
	// ----------------------------------------------------------------
	logic [`SWR_SRC_N-1:0] tick;

	swr_tick_sync #(
		.N(`SWR_SRC_N)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.slow_in({ref_div_clk, xtal_32k_clk, ring_2k_clk}),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	swr_state_e state_r, state_nxt;
	swr_word_t wcnt_r, wcnt_nxt;
	swr_word_t cmp_r, cmp_nxt;
	swr_word_t rtc_r, rtc_nxt;
	swr_word_t prdata_r, prdata_nxt;
	logic [`SWR_CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [`SWR_ST_W-1:0] stat_r, stat_nxt;
	logic [`SWR_ST_W-1:0] mask_r, mask_nxt;
	logic [3:0] wake_cnt_r, wake_cnt_nxt;
	logic doze_r, doze_nxt;
	logic freeze_r, freeze_nxt;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic acc, wr, rd_setup, hit;
	logic [`SWR_ST_W-1:0] w1c, st_set;
	logic enter, sleep_tick, rtc_tick;
	localparam logic [3:0] WAKE_LAST = 4'(WAKE_TICKS - 1);

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign hit = (paddr == `SWR_OFF_SLEEP_COUNT) || (paddr == `SWR_OFF_SLEEP_CMP) ||
		(paddr == `SWR_OFF_FREE_COUNT) || (paddr == `SWR_OFF_CTRL) ||
		(paddr == `SWR_OFF_STATUS) || (paddr == `SWR_OFF_MASK);
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata = prdata_r;
	assign w1c = (wr && paddr == `SWR_OFF_STATUS) ? pwdata[`SWR_ST_W-1:0] : `SWR_RST_ST;

	// Tick source per mode; doze input already carries the reference divided by SWR_REF_DIV
	assign sleep_tick = doze_r ? tick[`SWR_SRC_REF] :
		(ctrl_r[`SWR_CTRL_SLOW_XTAL] ? tick[`SWR_SRC_XTAL] : tick[`SWR_SRC_RING]);
	// Source switch simply changes which edges count
	assign rtc_tick = ctrl_r[`SWR_CTRL_FREE_EN] &
		(ctrl_r[`SWR_CTRL_FREE_XTAL] ? tick[`SWR_SRC_XTAL] : tick[`SWR_SRC_RING]);
	assign enter = (state_r == st_awake) & (hib_req | doze_req);

	// ----------------------------------------------------------------
	// Sleep sequence and wake-up counter
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		wcnt_nxt = wcnt_r;
		wake_cnt_nxt = wake_cnt_r;
		doze_nxt = doze_r;
		freeze_nxt = freeze_r;
		st_set = `SWR_RST_ST;
		case (state_r)
			st_awake: begin
				if (enter) begin
					wcnt_nxt = `SWR_RST_WORD;
					doze_nxt = doze_req;
					st_set[`SWR_ST_SYNC] = 1'b1;
					state_nxt = st_entry;
				end
			end
			st_entry: begin
				if (w1c[`SWR_ST_SYNC]) begin
					freeze_nxt = 1'b1;
					state_nxt = st_asleep;
				end
			end
			st_asleep: begin
				if (wcnt_r == cmp_r) begin
					st_set[`SWR_ST_TIMER] = 1'b1;
					st_set[`SWR_ST_HIB_WAKE] = ~doze_r & ctrl_r[`SWR_CTRL_WAKE_EN];
					wake_cnt_nxt = 4'h0;
					state_nxt = st_waking;
				end else if (sleep_tick) begin
					wcnt_nxt = 32'(wcnt_r + 32'h0000_0001);
				end
			end
			st_waking: begin
				if (sleep_tick) begin
					wcnt_nxt = 32'(wcnt_r + 32'h0000_0001);
					if (wake_cnt_r == WAKE_LAST) begin
						freeze_nxt = 1'b0;
						st_set[`SWR_ST_SYNC] = 1'b1;
						state_nxt = st_awake;
					end else begin
						wake_cnt_nxt = 4'(wake_cnt_r + 4'h1);
					end
				end
			end
			default: begin
				state_nxt = st_awake;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= st_awake;
			wcnt_r <= `SWR_RST_WORD;
			wake_cnt_r <= 4'h0;
			doze_r <= 1'b0;
			freeze_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			wcnt_r <= wcnt_nxt;
			wake_cnt_r <= wake_cnt_nxt;
			doze_r <= doze_nxt;
			freeze_r <= freeze_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Software registers, free-running counter and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		cmp_nxt = cmp_r;
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		prdata_nxt = prdata_r;
		// Free counter wraps naturally; no bus path reaches it
		rtc_nxt = rtc_tick ? 32'(rtc_r + 32'h0000_0001) : rtc_r;
		// Hardware set wins over the write-one clear
		stat_nxt = (stat_r & ~w1c) | st_set;
		if (wr && paddr == `SWR_OFF_SLEEP_CMP) begin
			cmp_nxt = pwdata;
		end
		if (wr && paddr == `SWR_OFF_CTRL) begin
			ctrl_nxt = pwdata[`SWR_CTRL_W-1:0];
		end
		if (wr && paddr == `SWR_OFF_MASK) begin
			mask_nxt = pwdata[`SWR_ST_W-1:0];
		end
		if (rd_setup) begin
			case (paddr)
				`SWR_OFF_SLEEP_COUNT: prdata_nxt = wcnt_r;
				`SWR_OFF_SLEEP_CMP: prdata_nxt = cmp_r;
				`SWR_OFF_FREE_COUNT: prdata_nxt = rtc_r;
				`SWR_OFF_CTRL: prdata_nxt = {28'h000_0000, ctrl_r};
				`SWR_OFF_STATUS: prdata_nxt = {29'h0000_0000, stat_r};
				`SWR_OFF_MASK: prdata_nxt = {29'h0000_0000, mask_r};
				default: prdata_nxt = `SWR_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_r <= `SWR_RST_WORD;
			ctrl_r <= `SWR_RST_CTRL;
			mask_r <= `SWR_RST_ST;
			stat_r <= `SWR_RST_ST;
			rtc_r <= `SWR_RST_WORD;
			prdata_r <= `SWR_RST_WORD;
		end else begin
			cmp_r <= cmp_nxt;
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			rtc_r <= rtc_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign irq = |(stat_r & mask_r);
	assign clk_freeze = freeze_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	entry_clear_a: assert property (enter |=> wcnt_r == 32'h0000_0000 && stat_r[`SWR_ST_SYNC])
		else $error("sleep entry did not clear counter and set sync");
	count_step_a: assert property (state_r == st_asleep && wcnt_r != cmp_r && sleep_tick
		|=> wcnt_r == 32'($past(wcnt_r) + 32'h0000_0001))
		else $error("sleep counter missed a tick");
	count_ro_a: assert property (state_r == st_awake && !enter |=> $stable(wcnt_r))
		else $error("sleep counter changed while awake");
	retain_cmp_a: assert property (freeze_r && !(wr && paddr == `SWR_OFF_SLEEP_CMP) |=> $stable(cmp_r))
		else $error("compare value lost during sleep");
	hib_src_a: assert property (state_r == st_asleep && !doze_r && wcnt_r != cmp_r
		&& !ctrl_r[`SWR_CTRL_SLOW_XTAL] && !tick[`SWR_SRC_RING] |=> $stable(wcnt_r))
		else $error("hibernate counter moved without ring tick");
	doze_src_a: assert property (state_r == st_asleep && doze_r && !tick[`SWR_SRC_REF] |=> $stable(wcnt_r))
		else $error("doze counter moved without reference tick");
	cmp_write_a: assert property (wr && paddr == `SWR_OFF_SLEEP_CMP |=> cmp_r == $past(pwdata))
		else $error("compare write not stored");
	wake_point_a: assert property (state_r == st_waking && state_nxt == st_awake
		|=> stat_r[`SWR_ST_SYNC] && !freeze_r && wcnt_r == 32'(cmp_r + 32'(WAKE_TICKS)))
		else $error("wake point not at compare plus wake ticks");
	free_step_a: assert property (rtc_tick |=> rtc_r == 32'($past(rtc_r) + 32'h0000_0001))
		else $error("free counter did not advance");
	free_hold_a: assert property (!rtc_tick |=> $stable(rtc_r))
		else $error("free counter moved without enabled tick");
	hib_flag_a: assert property ($rose(stat_r[`SWR_ST_HIB_WAKE]) |-> $past(ctrl_r[`SWR_CTRL_WAKE_EN])
		&& !$past(doze_r))
		else $error("hibernate wake flag set without enable");
	timer_event_a: assert property (state_r == st_asleep && wcnt_r == cmp_r
		|=> state_r == st_waking && stat_r[`SWR_ST_TIMER])
		else $error("compare match raised no timer event");
	freeze_on_a: assert property (state_r == st_entry && w1c[`SWR_ST_SYNC] |=> freeze_r)
		else $error("clearing sync on entry did not freeze clocks");
	entry_awake_a: assert property (state_r == st_entry |-> !freeze_r)
		else $error("clocks frozen before sync flag was cleared");
	awake_run_a: assert property (state_r == st_awake |-> !freeze_r)
		else $error("clocks frozen while awake");
	hib_clear_a: assert property (w1c[`SWR_ST_HIB_WAKE] && !st_set[`SWR_ST_HIB_WAKE]
		|=> !stat_r[`SWR_ST_HIB_WAKE])
		else $error("hibernate wake flag not cleared by write one");
	flag_sticky_a: assert property (stat_r[`SWR_ST_HIB_WAKE] && !w1c[`SWR_ST_HIB_WAKE]
		|=> stat_r[`SWR_ST_HIB_WAKE])
		else $error("hibernate wake flag dropped without a clear");
	timer_sticky_a: assert property (stat_r[`SWR_ST_TIMER] && !w1c[`SWR_ST_TIMER]
		|=> stat_r[`SWR_ST_TIMER])
		else $error("timer event flag dropped without a clear");
	mask_write_a: assert property (wr && paddr == `SWR_OFF_MASK
		|=> mask_r == $past(pwdata[`SWR_ST_W-1:0]))
		else $error("mask write not stored");
	count_read_a: assert property (rd_setup && paddr == `SWR_OFF_SLEEP_COUNT
		|=> prdata == $past(wcnt_r))
		else $error("sleep counter read returned wrong value");
	free_read_a: assert property (rd_setup && paddr == `SWR_OFF_FREE_COUNT
		|=> prdata == $past(rtc_r))
		else $error("free counter read returned wrong value");
	free_ro_a: assert property (wr && paddr == `SWR_OFF_FREE_COUNT && !rtc_tick |=> $stable(rtc_r))
		else $error("bus write changed the free counter");
	wake_hold_a: assert property (state_r == st_waking && !sleep_tick |=> $stable(wcnt_r))
		else $error("sleep counter moved between wake ticks");

endmodule

`default_nettype wire

/* File: dv/swr_sleep_timers_test.sv */
// Self-checking bench for the sleep and free-running timers
`timescale 1ns/1ps
`default_nettype none
`include "swr_params.svh"

module swr_sleep_timers_test
	import swr_pkg::*;
;
	localparam int WT = 2;
	swr_word_t pwdata, prdata, free_exp, cmp;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic hib_req, doze_req, clk_freeze, irq;
	logic [11:0] paddr;
	logic [2:0] slow;
	logic [3:0] ctrl_sh;
	swr_word_t exp_q[$];
	logic exp_e[$];
	int mismatches, num_checks, seed;
	logic [11:0] offs [6] = '{`SWR_OFF_SLEEP_COUNT, `SWR_OFF_SLEEP_CMP, `SWR_OFF_FREE_COUNT,
		`SWR_OFF_CTRL, `SWR_OFF_STATUS, `SWR_OFF_MASK};
	logic [3:0] cvals [3] = '{4'h0, 4'h4, 4'hC};

	swr_sleep_timers #(.WAKE_TICKS(WT)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ring_2k_clk(slow[`SWR_SRC_RING]), .xtal_32k_clk(slow[`SWR_SRC_XTAL]), .ref_div_clk(slow[`SWR_SRC_REF]),
		.hib_req(hib_req), .doze_req(doze_req), .clk_freeze(clk_freeze), .irq(irq));

	// ----------------------------------------------------------------
	// Clock, compare, verdict
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input string nm, input swr_word_t e, input swr_word_t g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// APB master and read monitor
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input swr_word_t d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input swr_word_t e, input logic er);
		exp_q.push_back(e);
		exp_e.push_back(er);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			chk("prdata", exp_q.pop_front(), prdata);
			chk("pslverr", swr_word_t'(exp_e.pop_front()), swr_word_t'(pslverr));
		end
	end

	// ----------------------------------------------------------------
	// Slow clock ticks and control shadow
	// ----------------------------------------------------------------
	task automatic tick(input int s);
		@(posedge pclk);
		slow[s] <= 1'b1;
		repeat (4) @(posedge pclk);
		slow[s] <= 1'b0;
		repeat (3) @(posedge pclk);
		if (ctrl_sh[2] && s == (ctrl_sh[3] ? `SWR_SRC_XTAL : `SWR_SRC_RING)) free_exp++;
	endtask

	task automatic wc(input logic [3:0] c);
		apb(1'b1, `SWR_OFF_CTRL, swr_word_t'(c));
		ctrl_sh = c;
	endtask

	// ----------------------------------------------------------------
	// One sleep cycle: entry, freeze, count, wake
	// ----------------------------------------------------------------
	task automatic sleep_run(input logic dz, input logic [3:0] c, input int src, input logic hib);
		int n;
		n = 0;
		cmp = ($unsigned($random(seed)) % 4) + 1;
		apb(1'b1, `SWR_OFF_SLEEP_CMP, cmp);
		apb(1'b1, `SWR_OFF_MASK, dz ? 32'h0000_0000 : 32'h0000_0004);
		wc(c);
		@(posedge pclk);
		if (dz) doze_req <= 1'b1;
		else hib_req <= 1'b1;
		@(posedge pclk);
		doze_req <= 1'b0;
		hib_req <= 1'b0;
		rd(`SWR_OFF_STATUS, 32'h0000_0001, 1'b0);
		rd(`SWR_OFF_SLEEP_COUNT, 32'h0000_0000, 1'b0);
		chk("clk_freeze", 32'h0000_0000, swr_word_t'(clk_freeze));
		apb(1'b1, `SWR_OFF_STATUS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk("clk_freeze", 32'h0000_0001, swr_word_t'(clk_freeze));
		tick((src + 1) % 3);
		tick((src + 2) % 3);
		repeat (cmp + WT - 1) tick(src);
		chk("clk_freeze", 32'h0000_0001, swr_word_t'(clk_freeze));
		tick(src);
		while (clk_freeze !== 1'b0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk("clk_freeze", 32'h0000_0000, swr_word_t'(clk_freeze));
		chk("irq", swr_word_t'(!dz), swr_word_t'(irq));
		rd(`SWR_OFF_STATUS, {29'h0000_0000, 1'b1, hib, 1'b1}, 1'b0);
		rd(`SWR_OFF_SLEEP_COUNT, cmp + WT, 1'b0);
		rd(`SWR_OFF_SLEEP_CMP, cmp, 1'b0);
		rd(`SWR_OFF_FREE_COUNT, free_exp, 1'b0);
		apb(1'b1, `SWR_OFF_STATUS, 32'h0000_0007);
		rd(`SWR_OFF_STATUS, 32'h0000_0000, 1'b0);
		@(posedge pclk);
		chk("irq", 32'h0000_0000, swr_word_t'(irq));
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h17d5;
		{psel, penable, pwrite, hib_req, doze_req} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		slow = 3'h0;
		ctrl_sh = 4'h0;
		free_exp = 32'h0000_0000;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (offs[i]) rd(offs[i], `SWR_RST_WORD, 1'b0);
		rd(12'h030, 32'h0000_0000, 1'b1);
		cmp = $random(seed);
		apb(1'b1, `SWR_OFF_SLEEP_CMP, cmp);
		rd(`SWR_OFF_SLEEP_CMP, cmp, 1'b0);
		apb(1'b1, `SWR_OFF_SLEEP_COUNT, ~cmp);
		apb(1'b1, `SWR_OFF_FREE_COUNT, cmp);
		rd(`SWR_OFF_SLEEP_COUNT, 32'h0000_0000, 1'b0);
		rd(`SWR_OFF_FREE_COUNT, 32'h0000_0000, 1'b0);
		foreach (cvals[i]) begin
			wc(cvals[i]);
			repeat (6) tick($unsigned($random(seed)) % 3);
			rd(`SWR_OFF_FREE_COUNT, free_exp, 1'b0);
		end
		sleep_run(1'b0, 4'b0110, `SWR_SRC_RING, 1'b1);
		sleep_run(1'b0, 4'b1101, `SWR_SRC_XTAL, 1'b0);
		sleep_run(1'b1, 4'b0110, `SWR_SRC_REF, 1'b0);
		@(posedge pclk);
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
